// ---- common/epi_pkg.sv ----
/*
 * Shared constants for the external pin interrupt block: register indices,
 * field layouts, reset values and sense encodings.
 * Assumes a 32-bit classic Wishbone bus whose byte address is four times
 * the register index.
 */
// Contract
// - Enabled pins still trigger interrupts while the pins are driven as outputs.
// - Group 3 covers inputs 31:24, group 2 23:16, group 1 15:8, group 0 7:0.
// - Four per-bank mask registers choose which inputs feed each group.
// - Pin changes are seen without the clock so they can wake from sleep.
// - Pin change interrupt needs the clock; a change undone before wake raises none.
// - Two sense bits per pin: 00 low, 01 any edge, 10 falling, 11 rising.
// - Enabled level-sensed request stays asserted while the pin stays low.
// - Low level and edges on dedicated pins are seen without the clock.
// - Sense register bits 7:6 always read as zero.
// - Dedicated interrupt needs its enable bit and the global flag both set.
// - Trigger sets the pending flag; vector taken or writing one clears it.
// - Pending flag reads zero while its pin uses level sense.
// - Sleeping with a request disabled gates its input; the change may set flags.
// - Group enables 3 and 2 with the global flag let bank changes raise vectors.
// - Group enables 1 and 0 gate groups 1 and 0 the same way.
// - Each group has a pending flag, set by bank change, cleared by vector or one.
// - Set mask bit enables its input; cleared bit disables it; masks reset to zero.
package epi_pkg;

    // ========================================================================
    // Sizes
    // ========================================================================
    localparam int unsigned NUM_DED = 3;
    localparam int unsigned NUM_TOG = 32;
    localparam int unsigned NUM_BANK = 4;
    localparam int unsigned BANK_W = 8;
    localparam int unsigned SENSE_W = 2;
    localparam int unsigned REG_W = 8;
    localparam int unsigned IDX_W = 8;
    localparam int unsigned ADR_LSB = 2;
    localparam int unsigned ADR_MSB = 9;
    localparam int unsigned NUM_VEC = 7;
    localparam int unsigned VEC_GRP_LSB = 3;

    // ========================================================================
    // Register indices (byte address is index times four)
    // ========================================================================
    localparam logic [7:0] IDX_EXT_EN = 8'h3D;
    localparam logic [7:0] IDX_GRP_EN = 8'h68;
    localparam logic [NUM_BANK-1:0][7:0] IDX_MASK = {8'h73, 8'h6D, 8'h6C, 8'h6B};
    localparam logic [7:0] IDX_SENSE = 8'h80;
    localparam logic [7:0] IDX_EXT_FLAG = 8'h81;
    localparam logic [7:0] IDX_GRP_FLAG = 8'h82;

    // ========================================================================
    // Reset values
    // ========================================================================
    localparam logic [NUM_DED-1:0] EXT_EN_RST = 3'h0;
    localparam logic [NUM_BANK-1:0] GRP_EN_RST = 4'h0;
    localparam logic [NUM_DED*SENSE_W-1:0] SENSE_RST = 6'h00;
    localparam logic [NUM_TOG-1:0] MASK_RST = 32'h0000_0000;
    localparam logic [NUM_DED-1:0] EXT_FLAG_RST = 3'h0;
    localparam logic [NUM_BANK-1:0] GRP_FLAG_RST = 4'h0;

    // Level seen from a pin whose input buffer is switched off in sleep
    localparam logic BUF_OFF_LEVEL = 1'b0;

    // ========================================================================
    // Sense encodings
    // ========================================================================
    localparam logic [1:0] SENSE_LOW = 2'h0;
    localparam logic [1:0] SENSE_ANY = 2'h1;
    localparam logic [1:0] SENSE_FALL = 2'h2;
    localparam logic [1:0] SENSE_RISE = 2'h3;

    // Trigger condition of one dedicated pin for a sense setting
    function automatic logic sense_hit(input logic [1:0] sel, input logic cur, input logic prev);
        logic hit;
        hit = 1'b0;
        unique case (sel)
            SENSE_LOW: hit = !cur;
            SENSE_ANY: hit = cur != prev;
            SENSE_FALL: hit = prev && !cur;
            SENSE_RISE: hit = cur && !prev;
        endcase
        return hit;
    endfunction : sense_hit

endpackage : epi_pkg

// ---- core/epi_sync.sv ----
/*
 * Two-flop synchroniser for a vector of pin levels.
 * Assumes every bit is an independent level from outside the clock domain.
 */
module epi_sync #(
    parameter int unsigned W = 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } epi_sync_s;

    epi_sync_s st_q;
    epi_sync_s st_d;

    // ========================================================================
    // Next state
    // ========================================================================
    always_comb begin
        st_d = st_q;
        st_d.s1 = d;
        st_d.s2 = st_q.s1;
    end

    // ========================================================================
    // Registers
    // ========================================================================
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign q = st_q.s2;

endmodule : epi_sync

// ---- core/epi_top.sv ----
/*
 * External pin interrupt block: three dedicated request pins with
 * selectable sense and 32 pin-change inputs in four banks of eight,
 * reached over a classic Wishbone slave.
 * Assumes pins are asynchronous, the processor status I bit and the
 * vector-taken pulses come from the CORE_CLK domain, and the core drops
 * a vector-taken pulse after one cycle.
 */
module epi_top (
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [9:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic [2:0] DEDICATED_REQUEST_PINS,
    input wire logic [31:0] TOGGLE_WATCH_INPUTS,
    input wire logic GLOBAL_IRQ_ENABLE,
    input wire logic SLEEP_ACTIVE,
    input wire logic [6:0] VECTOR_TAKEN,
    output logic [2:0] DEDICATED_IRQ,
    output logic [3:0] TOGGLE_GROUP_IRQ,
    output logic WAKE_REQUEST
);

    localparam int unsigned NDED = epi_pkg::NUM_DED;
    localparam int unsigned NTOG = epi_pkg::NUM_TOG;
    localparam int unsigned NBANK = epi_pkg::NUM_BANK;
    localparam int unsigned BW = epi_pkg::BANK_W;
    localparam int unsigned SW = epi_pkg::SENSE_W;
    localparam int unsigned RW = epi_pkg::REG_W;
    localparam int unsigned VG = epi_pkg::VEC_GRP_LSB;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [NDED-1:0] ext_en;
        logic [NBANK-1:0] grp_en;
        logic [NDED*SW-1:0] sense;
        logic [NTOG-1:0] tog_mask;
        logic [NDED-1:0] ext_flag;
        logic [NBANK-1:0] grp_flag;
        logic [NDED-1:0] ded_prev;
        logic [NTOG-1:0] tog_prev;
    } epi_state_s;

    epi_state_s st_q;
    epi_state_s st_d;

    logic [NDED-1:0] ded_sync;
    logic [NTOG-1:0] tog_sync;
    logic [NDED-1:0] level_mode;
    logic [NDED-1:0] ded_eff;
    logic [NDED-1:0] ded_hit;
    logic [NDED-1:0] ded_wake;
    logic [NDED-1:0] ded_clr;
    logic [NBANK-1:0] grp_hit;
    logic [NBANK-1:0] grp_wake;
    logic [NBANK-1:0] grp_clr;
    logic [epi_pkg::IDX_W-1:0] idx;
    logic req_new;
    logic wr_go;
    logic [31:0] rd_val;

    // ========================================================================
    // Pin synchronisers
    // ========================================================================
    // Pins are read whatever their port direction, so driving them raises interrupts
    epi_sync #(
        .W(NDED + NTOG)
    ) u_pin_sync (
        .clk(CORE_CLK),
        .nrst(NRST),
        .d({DEDICATED_REQUEST_PINS, TOGGLE_WATCH_INPUTS}),
        .q({ded_sync, tog_sync})
    );

    // ========================================================================
    // Bus decode
    // ========================================================================
    assign idx = WB_ADR_I[epi_pkg::ADR_MSB:epi_pkg::ADR_LSB];
    assign req_new = WB_CYC_I && WB_STB_I && !st_q.ack;
    // Writes land on the edge where the master sees ack
    assign wr_go = WB_CYC_I && WB_STB_I && WB_WE_I && st_q.ack && WB_SEL_I[0];

    // ========================================================================
    // Dedicated request pins
    // ========================================================================
    for (genvar n = 0; n < NDED; n++) begin : g_ded
        logic [1:0] sel;
        assign sel = st_q.sense[n*SW +: SW];
        assign level_mode[n] = sel == epi_pkg::SENSE_LOW;
        // Input buffer off in sleep while the request is disabled
        assign ded_eff[n] = (SLEEP_ACTIVE && !st_q.ext_en[n]) ? epi_pkg::BUF_OFF_LEVEL : ded_sync[n];
        assign ded_hit[n] = epi_pkg::sense_hit(sel, ded_eff[n], st_q.ded_prev[n]);
        // Raw pin path, needs no clock edge
        assign ded_wake[n] = st_q.ext_en[n]
            && epi_pkg::sense_hit(sel, DEDICATED_REQUEST_PINS[n], st_q.ded_prev[n]);
        assign ded_clr[n] = VECTOR_TAKEN[n] || (wr_go && idx == epi_pkg::IDX_EXT_FLAG && WB_DAT_I[n]);
        assign DEDICATED_IRQ[n] = GLOBAL_IRQ_ENABLE && st_q.ext_en[n]
            && (level_mode[n] ? !ded_eff[n] : st_q.ext_flag[n]);
    end

    // ========================================================================
    // Pin-change banks
    // ========================================================================
    for (genvar g = 0; g < NBANK; g++) begin : g_bank
        logic [BW-1:0] msk;
        assign msk = st_q.tog_mask[g*BW +: BW];
        // A change undone before the clock restarts never reaches the flag
        assign grp_hit[g] = |((tog_sync[g*BW +: BW] ^ st_q.tog_prev[g*BW +: BW]) & msk);
        assign grp_wake[g] = st_q.grp_en[g]
            && |((TOGGLE_WATCH_INPUTS[g*BW +: BW] ^ st_q.tog_prev[g*BW +: BW]) & msk);
        assign grp_clr[g] = VECTOR_TAKEN[VG + g] || (wr_go && idx == epi_pkg::IDX_GRP_FLAG && WB_DAT_I[g]);
        assign TOGGLE_GROUP_IRQ[g] = GLOBAL_IRQ_ENABLE && st_q.grp_en[g] && st_q.grp_flag[g];
    end

    assign WAKE_REQUEST = |ded_wake || |grp_wake;

    // ========================================================================
    // Read mux
    // ========================================================================
    always_comb begin
        rd_val = '0;
        case (idx)
            epi_pkg::IDX_EXT_EN: rd_val[NDED-1:0] = st_q.ext_en;
            epi_pkg::IDX_GRP_EN: rd_val[NBANK-1:0] = st_q.grp_en;
            epi_pkg::IDX_SENSE: rd_val[NDED*SW-1:0] = st_q.sense;
            epi_pkg::IDX_EXT_FLAG: rd_val[NDED-1:0] = st_q.ext_flag & ~level_mode;
            epi_pkg::IDX_GRP_FLAG: rd_val[NBANK-1:0] = st_q.grp_flag;
            default: begin
                for (int b = 0; b < NBANK; b++) begin
                    if (idx == epi_pkg::IDX_MASK[b]) begin
                        rd_val[RW-1:0] = st_q.tog_mask[b*BW +: BW];
                    end
                end
            end
        endcase
    end

    // ========================================================================
    // Next state
    // ========================================================================
    always_comb begin
        st_d = st_q;
        st_d.ack = req_new;
        if (req_new) begin
            st_d.rdata = rd_val;
        end
        st_d.ded_prev = ded_eff;
        st_d.tog_prev = tog_sync;
        if (wr_go) begin
            case (idx)
                epi_pkg::IDX_EXT_EN: st_d.ext_en = WB_DAT_I[NDED-1:0];
                epi_pkg::IDX_GRP_EN: st_d.grp_en = WB_DAT_I[NBANK-1:0];
                epi_pkg::IDX_SENSE: st_d.sense = WB_DAT_I[NDED*SW-1:0];
                default: begin
                    for (int b = 0; b < NBANK; b++) begin
                        if (idx == epi_pkg::IDX_MASK[b]) begin
                            st_d.tog_mask[b*BW +: BW] = WB_DAT_I[BW-1:0];
                        end
                    end
                end
            endcase
        end
        // Set beats clear; level sense holds the flag at zero
        for (int n = 0; n < NDED; n++) begin
            if (level_mode[n]) begin
                st_d.ext_flag[n] = 1'b0;
            end else if (ded_hit[n]) begin
                st_d.ext_flag[n] = 1'b1;
            end else if (ded_clr[n]) begin
                st_d.ext_flag[n] = 1'b0;
            end
        end
        for (int g = 0; g < NBANK; g++) begin
            if (grp_hit[g]) begin
                st_d.grp_flag[g] = 1'b1;
            end else if (grp_clr[g]) begin
                st_d.grp_flag[g] = 1'b0;
            end
        end
    end

    // ========================================================================
    // Registers
    // ========================================================================
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            st_q <= '0;
            st_q.ext_en <= epi_pkg::EXT_EN_RST;
            st_q.grp_en <= epi_pkg::GRP_EN_RST;
            st_q.sense <= epi_pkg::SENSE_RST;
            st_q.tog_mask <= epi_pkg::MASK_RST;
            st_q.ext_flag <= epi_pkg::EXT_FLAG_RST;
            st_q.grp_flag <= epi_pkg::GRP_FLAG_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign WB_ACK_O = st_q.ack;
    assign WB_DAT_O = st_q.rdata;

    // ========================================================================
    // Assertions
    // ========================================================================
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!NRST);

    property p_level_irq;
        (!DEDICATED_REQUEST_PINS[0] && st_q.ext_en[0] && st_q.sense[1:0] == epi_pkg::SENSE_LOW)[*3]
            ##0 GLOBAL_IRQ_ENABLE |-> DEDICATED_IRQ[0];
    endproperty
    a_level_irq: assert property (p_level_irq) else $error("level request not asserted");

    property p_level_flag_zero;
        st_q.sense[3:2] == epi_pkg::SENSE_LOW |=> !st_q.ext_flag[1];
    endproperty
    a_level_flag_zero: assert property (p_level_flag_zero) else $error("flag set in level mode");

    property p_rise_sets;
        $rose(DEDICATED_REQUEST_PINS[0]) && st_q.sense[1:0] == epi_pkg::SENSE_RISE && !SLEEP_ACTIVE
            ##1 (st_q.sense[1:0] == epi_pkg::SENSE_RISE && !SLEEP_ACTIVE)[*2] |=> st_q.ext_flag[0];
    endproperty
    a_rise_sets: assert property (p_rise_sets) else $error("rising edge missed");

    property p_toggle_sets;
        $changed(TOGGLE_WATCH_INPUTS[24]) && st_q.tog_mask[24] ##1 st_q.tog_mask[24][*2]
            |=> st_q.grp_flag[3];
    endproperty
    a_toggle_sets: assert property (p_toggle_sets) else $error("group three change missed");

    property p_mask_blocks;
        st_q.tog_mask[7:0] == 8'h00 && !st_q.grp_flag[0] |=> !st_q.grp_flag[0];
    endproperty
    a_mask_blocks: assert property (p_mask_blocks) else $error("masked input set flag");

    property p_ded_enable;
        DEDICATED_IRQ != 3'h0 |-> GLOBAL_IRQ_ENABLE && (DEDICATED_IRQ & ~st_q.ext_en) == 3'h0;
    endproperty
    a_ded_enable: assert property (p_ded_enable) else $error("request without enable");

    property p_group_enable;
        TOGGLE_GROUP_IRQ != 4'h0 |-> GLOBAL_IRQ_ENABLE && (TOGGLE_GROUP_IRQ & ~(st_q.grp_en & st_q.grp_flag)) == 4'h0;
    endproperty
    a_group_enable: assert property (p_group_enable) else $error("group request without enable");

    property p_vector_clear;
        VECTOR_TAKEN[VG] && !grp_hit[0] |=> !st_q.grp_flag[0];
    endproperty
    a_vector_clear: assert property (p_vector_clear) else $error("vector did not clear flag");

    property p_reserved;
        WB_ACK_O && !WB_WE_I && $past(idx) == epi_pkg::IDX_SENSE |-> WB_DAT_O[31:6] == 26'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved sense bits not zero");

    property p_sync_delay;
        $rose(st_q.grp_flag[0]) |-> $past(TOGGLE_WATCH_INPUTS[7:0], 3) != $past(TOGGLE_WATCH_INPUTS[7:0], 4);
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("flag set without synchronised change");

    property p_wake;
        st_q.grp_en[0] && st_q.tog_mask[7] && TOGGLE_WATCH_INPUTS[7] != st_q.tog_prev[7] |-> WAKE_REQUEST;
    endproperty
    a_wake: assert property (p_wake) else $error("pin change gave no wake");

    property p_ded_wake;
        st_q.ext_en[0] && st_q.sense[1:0] == epi_pkg::SENSE_LOW && !DEDICATED_REQUEST_PINS[0] |-> WAKE_REQUEST;
    endproperty
    a_ded_wake: assert property (p_ded_wake) else $error("low level gave no wake");

    property p_fall_sets;
        $fell(DEDICATED_REQUEST_PINS[1]) && st_q.sense[3:2] == epi_pkg::SENSE_FALL && !SLEEP_ACTIVE
            ##1 (st_q.sense[3:2] == epi_pkg::SENSE_FALL && !SLEEP_ACTIVE)[*2] |=> st_q.ext_flag[1];
    endproperty
    a_fall_sets: assert property (p_fall_sets) else $error("falling edge missed");

    property p_any_sets;
        $changed(DEDICATED_REQUEST_PINS[2]) && st_q.sense[5:4] == epi_pkg::SENSE_ANY && !SLEEP_ACTIVE
            ##1 (st_q.sense[5:4] == epi_pkg::SENSE_ANY && !SLEEP_ACTIVE)[*2] |=> st_q.ext_flag[2];
    endproperty
    a_any_sets: assert property (p_any_sets) else $error("any edge missed");

    property p_bank_one;
        $changed(TOGGLE_WATCH_INPUTS[15]) && st_q.tog_mask[15] ##1 st_q.tog_mask[15][*2] |=> st_q.grp_flag[1];
    endproperty
    a_bank_one: assert property (p_bank_one) else $error("group one change missed");

    property p_ext_w1c;
        wr_go && idx == epi_pkg::IDX_EXT_FLAG && WB_DAT_I[0] && !ded_hit[0] |=> !st_q.ext_flag[0];
    endproperty
    a_ext_w1c: assert property (p_ext_w1c) else $error("flag write did not clear");

    property p_grp_w1c;
        wr_go && idx == epi_pkg::IDX_GRP_FLAG && WB_DAT_I[1] && !grp_hit[1] |=> !st_q.grp_flag[1];
    endproperty
    a_grp_w1c: assert property (p_grp_w1c) else $error("group flag write did not clear");

    property p_ded_vector;
        VECTOR_TAKEN[2] && !ded_hit[2] |=> !st_q.ext_flag[2];
    endproperty
    a_ded_vector: assert property (p_ded_vector) else $error("vector did not clear request flag");

    property p_set_wins;
        ded_hit[1] && !level_mode[1] |=> st_q.ext_flag[1];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("request set lost");

    property p_grp_set;
        grp_hit[2] |=> st_q.grp_flag[2];
    endproperty
    a_grp_set: assert property (p_grp_set) else $error("group set lost");

    property p_sleep_gate;
        SLEEP_ACTIVE && !st_q.ext_en[1] && st_q.ded_prev[1]
            && st_q.sense[3:2] == epi_pkg::SENSE_ANY |=> st_q.ext_flag[1];
    endproperty
    a_sleep_gate: assert property (p_sleep_gate) else $error("gated input set no flag");

    property p_level_drop;
        (DEDICATED_REQUEST_PINS[0] && st_q.sense[1:0] == epi_pkg::SENSE_LOW)[*3] |-> !DEDICATED_IRQ[0];
    endproperty
    a_level_drop: assert property (p_level_drop) else $error("level request held after release");

    property p_group_irq;
        GLOBAL_IRQ_ENABLE && st_q.grp_en[1] && st_q.grp_flag[1] |-> TOGGLE_GROUP_IRQ[1];
    endproperty
    a_group_irq: assert property (p_group_irq) else $error("group one request missing");

    property p_no_wake;
        st_q.ext_en == 3'h0 && st_q.grp_en == 4'h0 |-> !WAKE_REQUEST;
    endproperty
    a_no_wake: assert property (p_no_wake) else $error("wake without enable");

    c_level_irq: cover property (DEDICATED_IRQ[0] && level_mode[0]);
    c_group3: cover property ($rose(st_q.grp_flag[3]));
    c_wake: cover property (WAKE_REQUEST && SLEEP_ACTIVE);
    c_w1c: cover property (wr_go && idx == epi_pkg::IDX_EXT_FLAG && st_q.ext_flag != 3'h0);

endmodule : epi_top

// ---- testbench/epi_core_model.sv ----
/*
 * Behavioural model of the processor interrupt sequencer beside the block.
 * Assumes request levels come from the CORE_CLK domain and that one
 * vector-taken pulse lasts exactly one cycle.
 */
module epi_core_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [2:0] ded_irq,
    input wire logic [3:0] grp_irq,
    input wire logic auto_take,
    input wire logic [3:0] take_wait,
    output logic [6:0] vector_taken,
    output int takes
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] pend;
    logic [3:0] wait_q;
    // ========================================================================
    // Vector fetch: lowest pending request after a set latency
    // ========================================================================
    assign pend = {grp_irq, ded_irq};
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            vector_taken <= 7'h00;
            wait_q <= 4'h0;
            takes <= 0;
        end else begin
            vector_taken <= 7'h00;
            if (auto_take && pend != 7'h00 && vector_taken == 7'h00) begin
                if (wait_q >= take_wait) begin
                    vector_taken <= pend & (~pend + 7'h01);
                    wait_q <= 4'h0;
                    takes <= takes + 1;
                end else begin
                    wait_q <= wait_q + 4'h1;
                end
            end else begin
                wait_q <= 4'h0;
            end
        end
    end
endmodule : epi_core_model

// ---- testbench/epi_top_test.sv ----
/*
 * Self-checking bench: register access, sense modes, pin-change banks,
 * vectors and wake of epi_top.
 * Assumes epi_core_model stands in for the processor sequencer.
 */
module epi_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] EN = epi_pkg::IDX_EXT_EN;
    localparam logic [7:0] GEN = epi_pkg::IDX_GRP_EN;
    localparam logic [7:0] SNS = epi_pkg::IDX_SENSE;
    localparam logic [7:0] EF = epi_pkg::IDX_EXT_FLAG;
    localparam logic [7:0] GF = epi_pkg::IDX_GRP_FLAG;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [9:0] adr = 10'h000;
    logic [3:0] sel = 4'h0;
    logic [31:0] dw = 32'h0;
    logic [31:0] dr;
    logic [31:0] rd;
    logic ack;
    logic [2:0] pins = 3'h7;
    logic [2:0] dirq;
    logic [31:0] tog = 32'h0;
    logic gie = 1'b0;
    logic slp = 1'b0;
    logic take = 1'b0;
    logic [3:0] twait = 4'h0;
    logic [6:0] vt;
    logic [3:0] girq;
    logic wake;
    int takes;
    int n_mismatch = 0;
    int tests_run = 0;

    always #12.5 clk = ~clk;

    epi_top i_dut (.CORE_CLK(clk), .NRST(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dw), .WB_DAT_O(dr), .WB_ACK_O(ack),
        .DEDICATED_REQUEST_PINS(pins), .TOGGLE_WATCH_INPUTS(tog), .GLOBAL_IRQ_ENABLE(gie),
        .SLEEP_ACTIVE(slp), .VECTOR_TAKEN(vt), .DEDICATED_IRQ(dirq), .TOGGLE_GROUP_IRQ(girq),
        .WAKE_REQUEST(wake));
    epi_core_model i_core (.clk(clk), .nrst(nrst), .ded_irq(dirq), .grp_irq(girq),
        .auto_take(take), .take_wait(twait), .vector_taken(vt), .takes(takes));

    // ========================================================================
    // Tasks
    // ========================================================================
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %08h expected %08h", $time, got, exp);
        end
    endtask : check

    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= 4'hF;
        dw <= {24'h0, wd};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 40);
        rd = dr;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (ack !== 1'b1) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask : wb

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
        wb(1'b0, idx, 8'h00);
        check(rd, exp);
    endtask : rdchk

    task automatic edges(input int k);
        repeat (k) @(posedge clk);
    endtask : edges

    // ========================================================================
    // Main sequence
    // ========================================================================
    initial begin
        edges(6);
        nrst <= 1'b1;
        for (int g = 0; g < 4; g++) rdchk(epi_pkg::IDX_MASK[g], 32'h0);
        rdchk(EN, 32'h0);
        rdchk(GEN, 32'h0);
        rdchk(EF, 32'h0);
        rdchk(GF, 32'h0);
        wb(1'b1, 8'h10, 8'hFF);
        rdchk(8'h10, 32'h0);
        wb(1'b1, EN, 8'hFF);
        rdchk(EN, 32'h07);
        wb(1'b1, GEN, 8'hFF);
        rdchk(GEN, 32'h0F);
        wb(1'b1, SNS, 8'hFF);
        rdchk(SNS, 32'h3F);
        wb(1'b1, EN, 8'h00);
        wb(1'b1, GEN, 8'h00);
        $display("Test registers done");
        for (int m = 1; m < 4; m++) begin
            wb(1'b1, SNS, {2'b00, m[1:0], m[1:0], m[1:0]});
            wb(1'b1, EF, 8'h07);
            @(posedge clk) pins <= 3'h0;
            edges(4);
            rdchk(EF, (m != 3) ? 32'h7 : 32'h0);
            wb(1'b1, EF, 8'h07);
            rdchk(EF, 32'h0);
            @(posedge clk) pins <= 3'h7;
            edges(4);
            rdchk(EF, (m != 2) ? 32'h7 : 32'h0);
            wb(1'b1, EF, 8'h07);
        end
        $display("Test sense modes done");
        @(posedge clk) pins <= 3'h0;
        edges(4);
        rdchk(EF, 32'h0);
        wb(1'b1, EN, 8'h04);
        gie <= 1'b1;
        @(posedge clk) pins <= 3'h7;
        edges(3);
        check(dirq, 32'h0);
        edges(1);
        check(dirq, 32'h4);
        gie <= 1'b0;
        edges(1);
        check(dirq, 32'h0);
        gie <= 1'b1;
        take <= 1'b1;
        edges(10);
        check(takes, 32'h1);
        rdchk(EF, 32'h3);
        take <= 1'b0;
        $display("Test vector done");
        wb(1'b1, EN, 8'h00);
        wb(1'b1, SNS, 8'h00);
        wb(1'b1, EF, 8'h07);
        wb(1'b1, EN, 8'h07);
        @(posedge clk) pins <= 3'h6;
        edges(4);
        check(dirq, 32'h1);
        rdchk(EF, 32'h0);
        edges(20);
        check(dirq, 32'h1);
        @(posedge clk) pins <= 3'h7;
        edges(4);
        check(dirq, 32'h0);
        wb(1'b1, EN, 8'h00);
        $display("Test level sense done");
        wb(1'b1, GEN, 8'h0F);
        for (int g = 0; g < 4; g++) begin
            wb(1'b1, epi_pkg::IDX_MASK[g], 8'h80);
            @(posedge clk) tog[8*g] <= 1'b1;
            edges(4);
            rdchk(GF, 32'h0);
            @(posedge clk) tog[8*g+7] <= 1'b1;
            edges(4);
            check(girq, 32'h1 << g);
            rdchk(GF, 32'h1 << g);
            wb(1'b1, GF, 8'h0F);
            rdchk(GF, 32'h0);
        end
        wb(1'b1, GEN, 8'h05);
        @(posedge clk) tog <= 32'h0;
        edges(4);
        check(girq, 32'h5);
        rdchk(GF, 32'hF);
        twait <= 4'h9;
        take <= 1'b1;
        edges(40);
        check(takes, 32'h3);
        rdchk(GF, 32'hA);
        take <= 1'b0;
        $display("Test pin change banks done");
        gie <= 1'b0;
        slp <= 1'b1;
        @(posedge clk) tog[7] <= 1'b1;
        #1;
        check(wake, 32'h1);
        edges(5);
        check(wake, 32'h0);
        slp <= 1'b0;
        wb(1'b1, SNS, 8'h15);
        edges(4);
        wb(1'b1, EF, 8'h07);
        @(posedge clk) slp <= 1'b1;
        edges(4);
        rdchk(EF, 32'h7);
        slp <= 1'b0;
        $display("Test sleep and wake done");
        tally_and_finish();
    end
endmodule : epi_top_test
